// [rtl/multicore_interrupt_distributor.sv]
// Interrupt distributor with four per-core interfaces, one clock, register port.
// Assumes clk is the distributor clock at half the core clock and bus_core names the accessor.
//
// What this block does
// - Each source has identifier, priority, target list.
// - IDs 0-15 software-only, banked per core.
// - Soft interrupt uses receiving core's priority.
// - Private timer is ID29, watchdog ID30.
// - Interface disabled: legacy line drives request.
// - Interface enabled: legacy line is ID31.
// - 224 lines from ID32, edge or level.
// - Fast inputs go straight to their core.
// - Assertion sets pending; level blocked while active.
// - Per-core selection, lowest identifier breaks ties.
// - Priority zero most urgent, 0xF least.
// - Equal soft interrupts: lowest source core wins.
// - Winner forwarded with its priority.
// - One-of-many: taking clears pending everywhere.
// - Every-core: taking clears only own pending.
// - Software-set pending behaves like hardware.
// - Accept only if beating mask and running.
// - Acknowledge records running priority, marks active.
// - Withdrawn before acknowledge returns 1023.
// - End-of-interrupt write moves active to inactive.
// - Logic at half core rate; pulses two cycles.
// - Global enable off forwards no distributed interrupt; fast inputs and the legacy bypass still pass.
// - Pending and active may coexist.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "mid_cfg.svh"
module multicore_interrupt_distributor (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Register port.
    input  wire logic [1:0]   bus_core,
    input  wire logic [11:0]  addr,
    input  wire logic [31:0]  wdata,
    input  wire logic         wr,
    input  wire logic         rd,
    output logic      [31:0]  rdata,
    // Interrupt inputs.
    input  wire logic [223:0] hw_irq,
    input  wire logic [3:0]   timer_irq,
    input  wire logic [3:0]   watchdog_irq,
    input  wire logic [3:0]   legacy_irq_line_n,
    input  wire logic [3:0]   fast_irq_input_n,
    // Requests to the cores.
    output logic      [3:0]   core_irq,
    output logic      [3:0]   core_fiq
);

    logic [`MID_NSYNC-1:0] sync1_reg;
    logic [`MID_NSYNC-1:0] sync2_reg;
    logic [`MID_NSYNC-1:0] sync3_reg;
    logic [223:0]          hw_lvl;
    logic [223:0]          hw_edge;
    logic [3:0]            tim_edge;
    logic [3:0]            wd_edge;
    logic [3:0]            leg_lvl;
    logic [3:0]            fiq_lvl;
    logic                  dist_en_reg;
    logic [3:0]            cif_en_reg;
    mid_pkg::prio_t        mask_reg [`MID_NCORE];
    mid_pkg::prio_t        bank_prio_reg [`MID_NCORE][`MID_NPRIV];
    mid_pkg::prio_t        hw_prio_reg [`MID_ID_HW_BASE:`MID_NID-1];
    mid_pkg::core_mask_t   hw_tgt_reg [`MID_ID_HW_BASE:`MID_NID-1];
    logic [255:32]         hw_level_reg;
    logic [255:32]         hw_nn_reg;
    logic [255:0]          pend_reg [`MID_NCORE];
    logic [3:0]            ipi_reg [`MID_NCORE][`MID_NIPI];
    logic [255:0]          act_reg [`MID_NCORE];
    logic [255:0]          pend_vec [`MID_NCORE];
    logic [255:0]          any_act;
    logic [255:32]         set_hw;
    mid_pkg::intid_t       best_id [`MID_NCORE];
    mid_pkg::run_prio_t    best_pr [`MID_NCORE];
    mid_pkg::run_prio_t    run_pr [`MID_NCORE];
    logic [3:0]            accept;
    logic [3:0]            core_irq_reg;
    logic [3:0]            core_fiq_reg;
    logic [31:0]           rdata_reg;
    logic                  ack_ok;
    mid_pkg::intid_t       ack_id;
    mid_pkg::core_t        ack_src;
    mid_pkg::intid_t       wid;
    mid_pkg::intid_t       cid;

    // Priority of an identifier as seen by one core; private ones are banked.
    function automatic mid_pkg::prio_t prio_of(input int c, input int i);
        if (i < `MID_NPRIV) begin
            prio_of = bank_prio_reg[c][i];
        end else begin
            prio_of = hw_prio_reg[i];
        end
    endfunction

    // Lowest-numbered sending core among set bits.
    function automatic mid_pkg::core_t lowest_src(input logic [3:0] s);
        lowest_src = 2'h0;
        for (int k = `MID_NCORE - 1; k >= 0; k--) begin
            if (s[k]) begin
                lowest_src = 2'(k);
            end
        end
    endfunction

    // Inputs cross three flip-flops; one clk cycle is two core cycles.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= {~fast_irq_input_n, ~legacy_irq_line_n, watchdog_irq, timer_irq, hw_irq};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Levels and rising edges taken from the second and third stages.
    assign hw_lvl   = sync2_reg[223:0];
    assign hw_edge  = sync2_reg[223:0] & ~sync3_reg[223:0];
    assign tim_edge = sync2_reg[227:224] & ~sync3_reg[227:224];
    assign wd_edge  = sync2_reg[231:228] & ~sync3_reg[231:228];
    assign leg_lvl  = sync2_reg[235:232];
    assign fiq_lvl  = sync2_reg[239:236];
    assign wid      = wdata[7:0];
    assign cid      = addr[9:2];

    // Per-core pending view, active summary and hardware assertion detection.
    always_comb begin
        any_act = '0;
        for (int c = 0; c < `MID_NCORE; c++) begin
            pend_vec[c] = pend_reg[c];
            for (int i = 0; i < `MID_NIPI; i++) begin
                pend_vec[c][i] = |ipi_reg[c][i];
            end
            pend_vec[c][27:16] = '0;
            pend_vec[c][28]    = 1'b0;
            any_act = any_act | act_reg[c];
        end
        for (int i = `MID_ID_HW_BASE; i < `MID_NID; i++) begin
            // A level line is also held off in the cycle its acknowledge makes it active.
            set_hw[i] = hw_level_reg[i] ? (hw_lvl[i-32] && !any_act[i]
                        && !(ack_ok && ack_id == 8'(i))) : hw_edge[i-32];
        end
    end

    // Duplicated selection per core: strict compare keeps the lowest identifier.
    always_comb begin
        for (int c = 0; c < `MID_NCORE; c++) begin
            best_id[c] = 8'h00;
            best_pr[c] = `MID_PRIO_IDLE;
            run_pr[c]  = `MID_PRIO_IDLE;
            for (int i = 0; i < `MID_NID; i++) begin
                if (pend_vec[c][i] && {1'b0, prio_of(c, i)} < best_pr[c]) begin
                    best_pr[c] = {1'b0, prio_of(c, i)};
                    best_id[c] = 8'(i);
                end
                if (act_reg[c][i] && {1'b0, prio_of(c, i)} < run_pr[c]) begin
                    run_pr[c] = {1'b0, prio_of(c, i)};
                end
            end
            accept[c] = dist_en_reg && best_pr[c] != `MID_PRIO_IDLE
                        && best_pr[c] < {1'b0, mask_reg[c]} && best_pr[c] < run_pr[c];
        end
    end

    // Acknowledge decode against the accessing core's current choice.
    assign ack_ok  = rd && addr == `MID_A_CIF_ACK && accept[bus_core];
    assign ack_id  = best_id[bus_core];
    assign ack_src = lowest_src(ipi_reg[bus_core][ack_id[3:0]]);

    // Configuration: enables, masks, per-source priority, targets and trigger mode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dist_en_reg  <= 1'b0;
            cif_en_reg   <= 4'h0;
            hw_level_reg <= '0;
            hw_nn_reg    <= '0;
            for (int c = 0; c < `MID_NCORE; c++) begin
                mask_reg[c] <= `MID_MASK_RST;
                for (int i = 0; i < `MID_NPRIV; i++) begin
                    bank_prio_reg[c][i] <= `MID_PRIO_RST;
                end
            end
            for (int i = `MID_ID_HW_BASE; i < `MID_NID; i++) begin
                hw_prio_reg[i] <= `MID_PRIO_RST;
                hw_tgt_reg[i]  <= `MID_TGT_RST;
            end
        end else if (wr) begin
            if (addr == `MID_A_DIST_CTRL) begin
                dist_en_reg <= wdata[`MID_EN_BIT];
            end
            if (addr == `MID_A_CIF_CTRL) begin
                cif_en_reg[bus_core] <= wdata[`MID_EN_BIT];
            end
            if (addr == `MID_A_CIF_MASK) begin
                mask_reg[bus_core] <= wdata[3:0];
            end
            if (addr[11:10] == `MID_A_CFG_REGION) begin
                if (cid < 8'(`MID_NPRIV)) begin
                    bank_prio_reg[bus_core][cid[4:0]] <= wdata[3:0];
                end else begin
                    hw_prio_reg[cid]  <= wdata[3:0];
                    hw_tgt_reg[cid]   <= wdata[`MID_CFG_TGT_LSB +: 4];
                    hw_level_reg[cid] <= wdata[`MID_CFG_LVL_BIT];
                    hw_nn_reg[cid]    <= wdata[`MID_CFG_NN_BIT];
                end
            end
        end
    end

    // Pending for IDs 16 and up; clears first so that a same-cycle set wins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < `MID_NCORE; c++) begin
                pend_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < `MID_NCORE; c++) begin
                if (ack_ok && ack_id >= 8'(`MID_NIPI) && (bus_core == 2'(c)
                    || (ack_id >= 8'(`MID_ID_HW_BASE) && !hw_nn_reg[ack_id]))) begin
                    pend_reg[c][ack_id] <= 1'b0;
                end
                if (wr && addr == `MID_A_PEND_CLR
                    && (wid >= 8'(`MID_ID_HW_BASE) || bus_core == 2'(c))) begin
                    pend_reg[c][wid] <= 1'b0;
                end
                for (int i = `MID_ID_HW_BASE; i < `MID_NID; i++) begin
                    if (set_hw[i] && hw_tgt_reg[i][c]) begin
                        pend_reg[c][i] <= 1'b1;
                    end
                end
                if (tim_edge[c]) begin
                    pend_reg[c][`MID_ID_TIMER] <= 1'b1;
                end
                if (wd_edge[c]) begin
                    pend_reg[c][`MID_ID_WDOG] <= 1'b1;
                end
                if (cif_en_reg[c] && leg_lvl[c] && !act_reg[c][`MID_ID_LEGACY]
                    && !(ack_ok && bus_core == 2'(c) && ack_id == 8'(`MID_ID_LEGACY))) begin
                    pend_reg[c][`MID_ID_LEGACY] <= 1'b1;
                end
                if (wr && addr == `MID_A_PEND_SET && wid >= 8'(`MID_NIPI)
                    && (wid >= 8'(`MID_ID_HW_BASE) ? hw_tgt_reg[wid][c] : bus_core == 2'(c))) begin
                    pend_reg[c][wid] <= 1'b1;
                end
            end
        end
    end

    // Software interrupts keep one pending bit per sending core.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < `MID_NCORE; c++) begin
                for (int i = 0; i < `MID_NIPI; i++) begin
                    ipi_reg[c][i] <= 4'h0;
                end
            end
        end else begin
            if (ack_ok && ack_id < 8'(`MID_NIPI)) begin
                ipi_reg[bus_core][ack_id[3:0]][ack_src] <= 1'b0;
            end
            if (wr && addr == `MID_A_PEND_CLR && wid < 8'(`MID_NIPI)) begin
                ipi_reg[bus_core][wid[3:0]] <= 4'h0;
            end
            for (int d = 0; d < `MID_NCORE; d++) begin
                if (wr && addr == `MID_A_SOFT_INT && wdata[`MID_SOFT_TGT_LSB + d]) begin
                    ipi_reg[d][wdata[3:0]][bus_core] <= 1'b1;
                end
            end
            if (wr && addr == `MID_A_PEND_SET && wid < 8'(`MID_NIPI)) begin
                ipi_reg[bus_core][wid[3:0]][bus_core] <= 1'b1;
            end
        end
    end

    // Active bits: acknowledge sets, end-of-interrupt notice clears.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < `MID_NCORE; c++) begin
                act_reg[c] <= '0;
            end
        end else begin
            if (ack_ok) begin
                act_reg[bus_core][ack_id] <= 1'b1;
            end
            if (wr && addr == `MID_A_CIF_EOI) begin
                act_reg[bus_core][wid] <= 1'b0;
            end
        end
    end

    // Core requests: legacy bypass while the interface is off; fast inputs pass straight.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_irq_reg <= 4'h0;
            core_fiq_reg <= 4'h0;
        end else begin
            for (int c = 0; c < `MID_NCORE; c++) begin
                core_irq_reg[c] <= cif_en_reg[c] ? accept[c] : leg_lvl[c];
            end
            core_fiq_reg <= fiq_lvl;
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= 32'h0000_0000;
            if (rd) begin
                if (addr == `MID_A_DIST_CTRL) begin
                    rdata_reg <= {31'h0, dist_en_reg};
                end else if (addr == `MID_A_CIF_CTRL) begin
                    rdata_reg <= {31'h0, cif_en_reg[bus_core]};
                end else if (addr == `MID_A_CIF_MASK) begin
                    rdata_reg <= {28'h0, mask_reg[bus_core]};
                end else if (addr == `MID_A_CIF_ACK) begin
                    rdata_reg <= ack_ok ? {20'h0, (ack_id < 8'(`MID_NIPI)) ? ack_src : 2'h0,
                                           2'h0, ack_id}
                                        : {22'h0, `MID_ID_SPURIOUS};
                end else if (addr == `MID_A_CIF_RUN) begin
                    rdata_reg <= {27'h0, run_pr[bus_core]};
                end else if (addr == `MID_A_CIF_HPEND) begin
                    rdata_reg <= {11'h0, best_pr[bus_core], 8'h00, best_id[bus_core]};
                end else if (addr[11:10] == `MID_A_CFG_REGION) begin
                    if (cid < 8'(`MID_NPRIV)) begin
                        rdata_reg <= {28'h0, bank_prio_reg[bus_core][cid[4:0]]};
                    end else begin
                        rdata_reg <= {14'h0, hw_nn_reg[cid], hw_level_reg[cid], 4'h0,
                                      hw_tgt_reg[cid], 4'h0, hw_prio_reg[cid]};
                    end
                end
            end
        end
    end

    // Outputs straight from flip-flops.
    assign rdata    = rdata_reg;
    assign core_irq = core_irq_reg;
    assign core_fiq = core_fiq_reg;

    // Checks on the design's own behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SPURIOUS: assert property (
        rd && addr == `MID_A_CIF_ACK && !accept[bus_core] |=> rdata[9:0] == `MID_ID_SPURIOUS)
        else $error("Withdrawn interrupt did not read as spurious.");
    AST_ACK_ID: assert property (
        ack_ok |=> rdata[7:0] == $past(ack_id) && act_reg[$past(bus_core)][$past(ack_id)])
        else $error("Acknowledge returned wrong id or left it inactive.");
    AST_RUN_PRIO: assert property (
        ack_ok |=> run_pr[$past(bus_core)] <= $past(best_pr[bus_core]))
        else $error("Running priority not raised by acknowledge.");
    AST_EOI: assert property (
        wr && addr == `MID_A_CIF_EOI && bus_core == 2'h0 |=> !act_reg[0][$past(wid)])
        else $error("End of interrupt left the id active.");
    AST_LEGACY: assert property (
        !cif_en_reg[0] |=> core_irq[0] == $past(leg_lvl[0]))
        else $error("Legacy line did not drive the request.");
    AST_DIST_OFF: assert property (
        cif_en_reg[1] && !dist_en_reg |=> !core_irq[1])
        else $error("Request raised with distributor disabled.");
    AST_MASK: assert property (
        cif_en_reg[0] && best_pr[0] >= {1'b0, mask_reg[0]} |=> !core_irq[0])
        else $error("Request raised although masked.");
    AST_FIQ: assert property (
        ##3 core_fiq == ~$past(fast_irq_input_n, 3))
        else $error("Fast input not passed to its core.");
    AST_TIE: assert property (
        pend_vec[0][45] && pend_vec[0][50] && hw_prio_reg[45] == hw_prio_reg[50]
        && best_pr[0] == {1'b0, hw_prio_reg[45]} |-> best_id[0] <= 8'd45)
        else $error("Tie did not pick the lowest id.");

    COV_ACK: cover property (ack_ok ##[1:20] wr && addr == `MID_A_CIF_EOI);
    COV_SPUR: cover property (core_irq[0] ##1 rd && addr == `MID_A_CIF_ACK && !ack_ok);
    COV_IPI: cover property (ack_ok && ack_id < 8'(`MID_NIPI));
    COV_BOTH: cover property (act_reg[0][32] && pend_reg[0][32]);

endmodule

// [common/mid_cfg.svh]
// Constants of the interrupt distributor: offsets, field positions, reset values, counts.
// Assumes a single 12-bit word-aligned register port; included by its bare name.
`ifndef MID_CFG_SVH
`define MID_CFG_SVH

// Sizes.
`define MID_NCORE        4
`define MID_NHW          224
`define MID_NID          256
`define MID_NIPI         16
`define MID_NPRIV        32
`define MID_NSYNC        240

// Fixed identifiers and the idle running priority.
`define MID_ID_TIMER     29
`define MID_ID_WDOG      30
`define MID_ID_LEGACY    31
`define MID_ID_HW_BASE   32
`define MID_ID_SPURIOUS  10'h3ff
`define MID_PRIO_IDLE    5'h10

// Register offsets.
`define MID_A_DIST_CTRL  12'h000
`define MID_A_CIF_CTRL   12'h100
`define MID_A_CIF_MASK   12'h104
`define MID_A_CIF_ACK    12'h10c
`define MID_A_CIF_EOI    12'h110
`define MID_A_CIF_RUN    12'h114
`define MID_A_CIF_HPEND  12'h118
`define MID_A_PEND_SET   12'h200
`define MID_A_PEND_CLR   12'h280
`define MID_A_SOFT_INT   12'hf00
`define MID_A_CFG_REGION 2'h1

// Field positions.
`define MID_EN_BIT       0
`define MID_CFG_TGT_LSB  8
`define MID_CFG_LVL_BIT  16
`define MID_CFG_NN_BIT   17
`define MID_SOFT_TGT_LSB 16

// Reset values.
`define MID_MASK_RST     4'h0
`define MID_PRIO_RST     4'h0
`define MID_TGT_RST      4'h0

// Pulse rule: distributor clock is half the core clock, so one clk cycle is two core cycles.
`define MID_CORE_PER_DIST 2

`endif

// [common/mid_pkg.sv]
// Types shared by the interrupt distributor.
// Assumes the constants header is compiled with it.
package mid_pkg;
    typedef logic [3:0] prio_t;
    typedef logic [4:0] run_prio_t;
    typedef logic [7:0] intid_t;
    typedef logic [1:0] core_t;
    typedef logic [3:0] core_mask_t;
endpackage

// [sim/core_agent.sv]
// Model of the processor cores on the register port of the distributor.
// Assumes the bench calls its tasks; one access at a time, strobes one cycle long.
`timescale 1ns/1ps
`include "mid_cfg.svh"
module core_agent (
    // Clock and read data.
    input  wire logic        clk,
    input  wire logic [31:0] rdata,
    // Register port.
    output logic      [1:0]  bus_core,
    output logic      [11:0] addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd
);
    // Idle bus at time zero.
    initial begin
        bus_core = 2'h0;
        addr     = 12'h000;
        wdata    = 32'h0;
        wr       = 1'b0;
        rd       = 1'b0;
    end

    // One write cycle; released data shows its inverse so stale values never match.
    task automatic write(input logic [1:0] c, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_core <= c;
        addr     <= a;
        wdata    <= d;
        wr       <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
        addr  <= ~a;
    endtask

    // One read cycle; data are taken in the cycle after the strobe.
    task automatic read(input logic [1:0] c, input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_core <= c;
        addr     <= a;
        rd       <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask

    // The core takes its interrupt by reading the acknowledge register.
    task automatic take(input logic [1:0] c, output logic [31:0] d);
        read(c, `MID_A_CIF_ACK, d);
    endtask

    // The core ends its handler by writing the finished identifier.
    task automatic finish(input logic [1:0] c, input logic [7:0] id);
        write(c, `MID_A_CIF_EOI, {24'h0, id});
        repeat (2) @(posedge clk);
    endtask
endmodule

// [sim/multicore_interrupt_distributor_test.sv]
// Self-checking bench of the interrupt distributor with four modelled cores.
// Assumes core_agent drives the register port and mid_cfg.svh holds the offsets.
`timescale 1ns/1ps
`include "mid_cfg.svh"
module multicore_interrupt_distributor_test;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic [1:0]     bus_core;
    logic [11:0]    addr;
    logic [31:0]    wdata;
    logic           wr;
    logic           rd;
    logic [31:0]    rdata;
    logic [223:0]   hw_irq = '0;
    logic [3:0]     timer_irq = 4'h0;
    logic [3:0]     watchdog_irq = 4'h0;
    logic [3:0]     legacy_irq_line_n = 4'hf;
    logic [3:0]     fast_irq_input_n = 4'hf;
    logic [3:0]     core_irq;
    logic [3:0]     core_fiq;
    int             n_errors = 0;
    int             checks_done = 0;

    // Clock of 40 ns.
    always #20 clk = ~clk;

    // Cores on the register port and the block itself.
    core_agent i_core (.clk(clk), .rdata(rdata), .bus_core(bus_core), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    multicore_interrupt_distributor i_dut (.clk(clk), .rst_n(rst_n), .bus_core(bus_core),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hw_irq(hw_irq),
        .timer_irq(timer_irq), .watchdog_irq(watchdog_irq), .core_irq(core_irq),
        .legacy_irq_line_n(legacy_irq_line_n), .fast_irq_input_n(fast_irq_input_n),
        .core_fiq(core_fiq));

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // Waits a bounded time for the request of one core to reach a level.
    task automatic wait_irq(input int c, input logic e);
        for (int k = 0; k < 20 && core_irq[c] !== e; k++) @(posedge clk);
        #1;
        chk("core_irq", {31'h0, e}, {31'h0, core_irq[c]});
    endtask

    task automatic ack(input logic [1:0] c, input logic [31:0] e);
        logic [31:0] d;
        i_core.take(c, d);
        chk("ack", e, d);
    endtask

    task automatic cfg(input logic [7:0] id, input logic [31:0] v);
        i_core.write(2'h0, 12'h400 + {2'h0, id, 2'h0}, v);
    endtask

    // A hardware line held for two distributor cycles.
    task automatic pulse(input int b);
        @(posedge clk);
        hw_irq[b] <= 1'b1;
        repeat (2) @(posedge clk);
        hw_irq[b] <= 1'b0;
    endtask

    // Reset state, legacy bypass and fast inputs.
    task automatic t_start();
        logic [31:0] d;
        chk("irq at reset", 32'h0, {28'h0, core_irq});
        ack(2'h0, 32'h3ff);
        i_core.read(2'h0, `MID_A_CIF_RUN, d);
        chk("running", 32'h10, d);
        @(posedge clk);
        legacy_irq_line_n[2] <= 1'b0;
        wait_irq(2, 1'b1);
        @(posedge clk);
        legacy_irq_line_n[2] <= 1'b1;
        wait_irq(2, 1'b0);
        @(posedge clk);
        fast_irq_input_n[1] <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("core_fiq", 32'h2, {28'h0, core_fiq});
        @(posedge clk);
        fast_irq_input_n[1] <= 1'b1;
        i_core.write(2'h0, `MID_A_DIST_CTRL, 32'h1);
        for (int c = 0; c < 4; c++) begin
            i_core.write(2'(c), `MID_A_CIF_CTRL, 32'h1);
            i_core.write(2'(c), `MID_A_CIF_MASK, 32'hf);
        end
    endtask

    // Hardware edge, acknowledge, re-assertion while active, completion.
    task automatic t_hw();
        logic [31:0] d;
        cfg(8'd40, 32'h105);
        pulse(8);
        wait_irq(0, 1'b1);
        ack(2'h0, 32'd40);
        i_core.read(2'h0, `MID_A_CIF_RUN, d);
        chk("running", 32'h5, d);
        pulse(8);
        repeat (4) @(posedge clk);
        i_core.read(2'h0, `MID_A_CIF_HPEND, d);
        chk("pending", 32'h50028, d);
        chk("irq blocked", 32'h0, {31'h0, core_irq[0]});
        i_core.finish(2'h0, 8'd40);
        wait_irq(0, 1'b1);
        ack(2'h0, 32'd40);
        i_core.finish(2'h0, 8'd40);
        i_core.read(2'h0, `MID_A_CIF_RUN, d);
        chk("running", 32'h10, d);
        // A level line held high is not pending again while it is active.
        cfg(8'd42, 32'h10104);
        hw_irq[10] <= 1'b1;
        wait_irq(0, 1'b1);
        ack(2'h0, 32'd42);
        repeat (4) @(posedge clk);
        i_core.read(2'h0, `MID_A_CIF_HPEND, d);
        chk("level blocked", 32'h100000, d);
        @(posedge clk);
        hw_irq[10] <= 1'b0;
        repeat (3) @(posedge clk);
        i_core.finish(2'h0, 8'd42);
    endtask

    // One-of-many against every-core delivery to cores 0 and 1.
    task automatic t_model(input logic nn);
        cfg(8'd41, {14'h0, nn, 17'h0302});
        pulse(9);
        wait_irq(0, 1'b1);
        wait_irq(1, 1'b1);
        ack(2'h1, 32'd41);
        repeat (4) @(posedge clk);
        wait_irq(0, nn);
        ack(2'h0, nn ? 32'd41 : 32'h3ff);
        i_core.finish(2'h1, 8'd41);
        i_core.finish(2'h0, 8'd41);
    endtask

    // Ordering by priority and identifier, masking, software pending.
    task automatic t_prio();
        cfg(8'd50, 32'h103);
        cfg(8'd45, 32'h103);
        cfg(8'd60, 32'h101);
        i_core.write(2'h0, `MID_A_PEND_SET, 32'd50);
        i_core.write(2'h0, `MID_A_PEND_SET, 32'd45);
        i_core.write(2'h0, `MID_A_PEND_SET, 32'd60);
        wait_irq(0, 1'b1);
        ack(2'h0, 32'd60);
        ack(2'h0, 32'h3ff);
        i_core.finish(2'h0, 8'd60);
        ack(2'h0, 32'd45);
        i_core.finish(2'h0, 8'd45);
        i_core.write(2'h0, `MID_A_CIF_MASK, 32'h3);
        repeat (4) @(posedge clk);
        ack(2'h0, 32'h3ff);
        i_core.write(2'h0, `MID_A_DIST_CTRL, 32'h0);
        i_core.write(2'h0, `MID_A_CIF_MASK, 32'hf);
        repeat (4) @(posedge clk);
        #1;
        chk("irq disabled", 32'h0, {31'h0, core_irq[0]});
        i_core.write(2'h0, `MID_A_DIST_CTRL, 32'h1);
        wait_irq(0, 1'b1);
        i_core.write(2'h0, `MID_A_PEND_CLR, 32'd50);
        ack(2'h0, 32'h3ff);
    endtask

    // Soft interrupts from cores 2 and 1, then timer and watchdog.
    task automatic t_soft();
        logic [31:0] d;
        cfg(8'd3, 32'h4);
        i_core.write(2'h1, 12'h40c, 32'h0);
        i_core.write(2'h0, `MID_A_CIF_MASK, 32'h4);
        i_core.write(2'h2, `MID_A_SOFT_INT, 32'h10003);
        i_core.write(2'h1, `MID_A_SOFT_INT, 32'h10003);
        repeat (4) @(posedge clk);
        ack(2'h0, 32'h3ff);
        i_core.write(2'h0, `MID_A_CIF_MASK, 32'hf);
        wait_irq(0, 1'b1);
        ack(2'h0, 32'h403);
        i_core.finish(2'h0, 8'd3);
        ack(2'h0, 32'h803);
        i_core.finish(2'h0, 8'd3);
        for (int k = 0; k < 2; k++) begin
            cfg(8'(29 + k), 32'h1);
            {watchdog_irq[0], timer_irq[0]} <= 2'b01 << k;
            wait_irq(0, 1'b1);
            ack(2'h0, 32'(29 + k));
            @(posedge clk);
            {watchdog_irq[0], timer_irq[0]} <= 2'b00;
            i_core.finish(2'h0, 8'(29 + k));
        end
        // With the interface on, the legacy line is an ordinary level source.
        legacy_irq_line_n[0] <= 1'b0;
        wait_irq(0, 1'b1);
        ack(2'h0, 32'd31);
        @(posedge clk);
        legacy_irq_line_n[0] <= 1'b1;
        repeat (3) @(posedge clk);
        i_core.finish(2'h0, 8'd31);
        i_core.read(2'h0, `MID_A_CIF_HPEND, d);
        chk("legacy done", 32'h100000, d);
    endtask

    // Main sequence.
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_start();
        t_hw();
        t_model(1'b0);
        t_model(1'b1);
        t_prio();
        t_soft();
        complete_run();
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule
